//--- verilog/clie_engine.sv
// Instruction engine of a character display controller, with its event FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "clie_defs.svh"
////////////////////////////////////////////////////////////////////////
module clie_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // System clock.
  input  wire logic             reset,     // Synchronous reset.
  input  wire logic             in_valid,  // Word offered.
  output logic                  in_ready,  // Room for a word.
  input  wire logic [WIDTH-1:0] in_data,   // Word written.
  output logic                  out_valid, // Word available.
  input  wire logic             out_ready, // Consumer takes word.
  output logic      [WIDTH-1:0] out_data   // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } clie_fifo_st_t;
  clie_fifo_st_t st_reg;
  clie_fifo_st_t st_next;
  logic          full;
  logic          empty;
  assign full      = (st_reg.wr[AW] != st_reg.rd[AW]) && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
  assign empty     = st_reg.wr == st_reg.rd;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_reg.mem[st_reg.rd[AW-1:0]];
  always_comb begin
    st_next = st_reg;
    if (in_valid && !full) begin
      st_next.mem[st_reg.wr[AW-1:0]] = in_data;
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) st_reg <= '0;
    else st_reg <= st_next;
  end
endmodule : clie_fifo
////////////////////////////////////////////////////////////////////////
module clie_engine
  import clie_pkg::*;
(
  input  wire logic       clk,             // 10 MHz system clock.
  input  wire logic       reset,           // Synchronous reset, active high.
  input  wire logic       enable_strobe,   // One-cycle bus access strobe.
  input  wire logic       register_select, // 0 instruction, 1 data.
  input  wire logic       read_write,      // 1 read, 0 write.
  input  wire logic [7:0] data_in,         // Data lines as driven by host.
  output logic      [7:0] data_out,        // Data lines as driven by device.
  output logic            data_oe,         // Device drives data lines.
  input  wire logic       incr_decr,       // Entry direction, 1 increments.
  input  wire logic       auto_shift,      // Entry display shift on char_ram writes.
  output logic            busy_flag,       // Instruction in execution.
  output logic      [6:0] addr_counter,    // Shared RAM address.
  output logic            ram_is_glyph,    // Data goes to glyph_ram.
  output clie_cfg_t       cfg,             // Width, lines and font.
  output logic      [6:0] display_offset,  // Display shift of all lines.
  output logic            ev_valid,        // Display event available.
  input  wire logic       ev_ready,        // Display side takes event.
  output clie_event_t     ev_word          // Display event.
);
  typedef struct packed {
    logic [127:0][7:0]      char_ram;
    logic [63:0][7:0]       glyph_ram;
    clie_cfg_t              cfg;
    logic [6:0]             addr_counter;
    logic                   sel_glyph;
    logic                   busy_flag;
    logic [`CLIE_CNT_W-1:0] exec_cnt;
    clie_op_t               op;
    logic [7:0]             arg;
    logic [7:0]             read_latch;
    logic [6:0]             shift_offset;
    logic                   nib_lo;
    logic [3:0]             nib_hold;
    logic [7:0]             out_byte;
    logic [7:0]             data_out;
    logic                   data_oe;
  } clie_st_t;
  clie_st_t    st_reg;
  clie_st_t    st_next;
  clie_event_t push_word;
  logic        push;
  logic        needs_event;
  logic        fifo_ready;
  logic        finish;
  logic        bus8;
  logic        two_line;
  logic        byte_done;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic [6:0]  span;
  assign bus8     = st_reg.cfg.bus_width_sel;
  assign two_line = st_reg.cfg.line_count_sel;
  assign span     = two_line ? `CLIE_L1_END : `CLIE_ONE_END;
  // In 4-bit mode the byte completes on the second strobe; first holds the upper nibble.
  assign byte_done = bus8 || st_reg.nib_lo;
  assign wbyte     = bus8 ? data_in : {st_reg.nib_hold, data_in[7:4]};
  assign rbyte     = register_select ? st_reg.read_latch : {st_reg.busy_flag, st_reg.addr_counter};
  always_comb begin
    needs_event = (st_reg.op == OP_DATA_WR) || (st_reg.op == OP_SHIFT && st_reg.arg[`CLIE_SC_BIT]);
    push_word.kind = st_reg.sel_glyph ? EV_GLYPH_WR : EV_CHAR_WR;
    push_word.addr = st_reg.addr_counter;
    push_word.data = st_reg.arg;
    if (st_reg.op == OP_SHIFT) begin
      push_word.kind = st_reg.arg[`CLIE_RL_BIT] ? EV_SHIFT_R : EV_SHIFT_L;
    end
  end
  // A full event queue holds the instruction busy rather than losing the event.
  assign finish = st_reg.busy_flag && st_reg.exec_cnt == `CLIE_CNT_W'(1) && (!needs_event || fifo_ready);
  assign push   = finish && needs_event;
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.data_oe = 1'b0;
    if (enable_strobe) begin
      if (!bus8) begin
        st_next.nib_lo = !st_reg.nib_lo;
        if (!st_reg.nib_lo) st_next.nib_hold = data_in[7:4];
      end
      if (read_write) begin
        st_next.data_oe = 1'b1;
        if (bus8) begin
          st_next.data_out = rbyte;
        end else if (!st_reg.nib_lo) begin
          st_next.out_byte = rbyte;
          st_next.data_out = {rbyte[7:4], 4'h0};
        end else begin
          st_next.data_out = {st_reg.out_byte[3:0], 4'h0};
        end
      end
      // Status reads are always answered; everything else is dropped while busy.
      if (byte_done && !st_reg.busy_flag && !(read_write && !register_select)) begin
        st_next.busy_flag = 1'b1;
        st_next.exec_cnt  = `CLIE_CNT_W'(`CLIE_EXEC_CYCLES);
        st_next.arg       = wbyte;
        if (register_select) st_next.op = read_write ? OP_DATA_RD : OP_DATA_WR;
        else st_next.op = clie_decode(wbyte);
      end
    end
    if (st_reg.busy_flag && st_reg.exec_cnt != `CLIE_CNT_W'(1)) begin
      st_next.exec_cnt = st_reg.exec_cnt - `CLIE_CNT_W'(1);
    end
    // All effects land as the busy flag drops.
    if (finish) begin
      st_next.busy_flag = 1'b0;
      unique case (st_reg.op)
        OP_SHIFT: begin
          if (st_reg.arg[`CLIE_SC_BIT]) begin
            // One offset for every line; the cursor rides with it and the counter stays.
            if (!st_reg.arg[`CLIE_RL_BIT]) begin
              st_next.shift_offset = st_reg.shift_offset >= span ? 7'h00 : st_reg.shift_offset + 7'h01;
            end else begin
              st_next.shift_offset = st_reg.shift_offset == 7'h00 ? span : st_reg.shift_offset - 7'h01;
            end
          end else begin
            st_next.addr_counter = clie_step(st_reg.addr_counter, st_reg.arg[`CLIE_RL_BIT],
                                             st_reg.sel_glyph, two_line);
            st_next.read_latch = st_reg.char_ram[st_next.addr_counter];
          end
        end
        OP_CONFIG: begin
          st_next.cfg.bus_width_sel  = st_reg.arg[`CLIE_DL_BIT];
          st_next.cfg.line_count_sel = st_reg.arg[`CLIE_N_BIT];
          st_next.cfg.font_sel       = st_reg.arg[`CLIE_F_BIT];
          st_next.nib_lo             = 1'b0;
        end
        OP_GLYPH_ADDR: begin
          st_next.addr_counter = {1'b0, st_reg.arg[5:0]};
          st_next.sel_glyph    = 1'b1;
          st_next.read_latch   = st_reg.glyph_ram[st_reg.arg[5:0]];
        end
        OP_CHAR_ADDR: begin
          st_next.addr_counter = st_reg.arg[6:0];
          st_next.sel_glyph    = 1'b0;
          st_next.read_latch   = st_reg.char_ram[st_reg.arg[6:0]];
        end
        OP_DATA_WR: begin
          // No latch refresh here, so a read straight after a write returns stale data.
          if (st_reg.sel_glyph) st_next.glyph_ram[st_reg.addr_counter[5:0]] = st_reg.arg;
          else st_next.char_ram[st_reg.addr_counter] = st_reg.arg;
          st_next.addr_counter = clie_step(st_reg.addr_counter, incr_decr,
                                           st_reg.sel_glyph, two_line);
          if (auto_shift && !st_reg.sel_glyph) begin
            if (incr_decr) st_next.shift_offset = st_reg.shift_offset >= span ? 7'h00 : st_reg.shift_offset + 7'h01;
            else st_next.shift_offset = st_reg.shift_offset == 7'h00 ? span : st_reg.shift_offset - 7'h01;
          end
        end
        OP_DATA_RD: begin
          st_next.addr_counter = clie_step(st_reg.addr_counter, incr_decr,
                                           st_reg.sel_glyph, two_line);
          st_next.read_latch = st_reg.sel_glyph ? st_reg.glyph_ram[st_next.addr_counter[5:0]]
                                                : st_reg.char_ram[st_next.addr_counter];
        end
        OP_OTHER: begin
        end
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg     <= '0;
      st_reg.cfg <= `CLIE_CFG_RESET;
      st_reg.op  <= OP_OTHER;
    end else begin
      st_reg <= st_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  clie_fifo #(
    .WIDTH ($bits(clie_event_t)),
    .DEPTH (`CLIE_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (ev_valid),
    .out_ready (ev_ready),
    .out_data  (ev_word)
  );
  assign data_out       = st_reg.data_out;
  assign data_oe        = st_reg.data_oe;
  assign busy_flag      = st_reg.busy_flag;
  assign addr_counter   = st_reg.addr_counter;
  assign ram_is_glyph   = st_reg.sel_glyph;
  assign cfg            = st_reg.cfg;
  assign display_offset = st_reg.shift_offset;
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic take;
  assign take = enable_strobe && byte_done && !st_reg.busy_flag && !(read_write && !register_select);
  AST_BUSY_HOLD: assert property (take |=> busy_flag [*8])
    else $error("busy flag dropped early");
  AST_REFUSE: assert property (st_reg.busy_flag && !finish && enable_strobe |=> $stable(st_reg.arg))
    else $error("instruction taken while busy");
  AST_STATUS: assert property (bus8 && enable_strobe && read_write && !register_select
                               |=> data_oe && data_out == {$past(busy_flag), $past(addr_counter)})
    else $error("status read wrong");
  AST_DISP_AC: assert property (finish && st_reg.op == OP_SHIFT && st_reg.arg[`CLIE_SC_BIT]
                                |=> $stable(addr_counter) && $changed(display_offset))
    else $error("display shift touched counter");
  // Cursor moves away from the line ends step the shared counter by exactly one.
  AST_CURSOR: assert property (finish && st_reg.op == OP_SHIFT && !st_reg.arg[`CLIE_SC_BIT]
                               && st_reg.arg[`CLIE_RL_BIT] && !ram_is_glyph
                               && addr_counter != `CLIE_L1_END && addr_counter != `CLIE_L2_END
                               && addr_counter != `CLIE_ONE_END
                               |=> addr_counter == $past(addr_counter) + 7'h01)
    else $error("cursor right did not increment");
  AST_CURSOR_LEFT: assert property (finish && st_reg.op == OP_SHIFT && !st_reg.arg[`CLIE_SC_BIT]
                                    && !st_reg.arg[`CLIE_RL_BIT] && !ram_is_glyph
                                    && addr_counter != `CLIE_L1_BASE && addr_counter != `CLIE_L2_BASE
                                    |=> addr_counter == $past(addr_counter) - 7'h01)
    else $error("cursor left did not decrement");
  AST_CONFIG: assert property (finish && st_reg.op == OP_CONFIG |=> cfg == $past(st_reg.arg[4:2]))
    else $error("configuration not applied");
  AST_GLYPH: assert property (finish && st_reg.op == OP_GLYPH_ADDR
                              |=> ram_is_glyph && addr_counter == {1'b0, $past(st_reg.arg[5:0])})
    else $error("glyph address load wrong");
  AST_CHAR: assert property (finish && st_reg.op == OP_CHAR_ADDR
                             |=> !ram_is_glyph && addr_counter == $past(st_reg.arg[6:0]))
    else $error("char address load wrong");
  AST_WRAP: assert property (finish && st_reg.op == OP_DATA_WR && two_line && !ram_is_glyph && incr_decr
                             && addr_counter == 7'h27 |=> addr_counter == 7'h40)
    else $error("line wrap wrong");
  AST_READ: assert property (finish && st_reg.op == OP_DATA_RD |=> $stable(display_offset))
    else $error("read shifted display");
  AST_AC_HOLD: assert property (busy_flag && !finish |=> $stable(addr_counter))
    else $error("counter moved while busy");
  ////////////////////////////////////////////////////////////////////////
  // The checks below watch the line ends and the bus answer.
  // A wrong wrap would only show up much later as a misplaced character,
  // so the counter is pinned down at the very edge where it moves.
  AST_ONE_WRAP: assert property (finish && st_reg.op == OP_DATA_WR && !two_line && !ram_is_glyph
                                 && incr_decr && addr_counter == `CLIE_ONE_END
                                 |=> addr_counter == `CLIE_L1_BASE)
    else $error("one-line wrap wrong");
  AST_RD_STEP: assert property (finish && st_reg.op == OP_DATA_RD && !ram_is_glyph && incr_decr
                                && addr_counter != `CLIE_L1_END && addr_counter != `CLIE_L2_END
                                && addr_counter != `CLIE_ONE_END
                                |=> addr_counter == $past(addr_counter) + 7'h01)
    else $error("read did not step counter");
  // Glyph accesses never reach the upper half of the counter.
  AST_GLYPH_WRAP: assert property (finish && ram_is_glyph
                                   && (st_reg.op == OP_DATA_WR || st_reg.op == OP_DATA_RD)
                                   |=> !addr_counter[6])
    else $error("glyph counter left its range");
  AST_GLYPH_NOSHIFT: assert property (finish && st_reg.op == OP_DATA_WR && ram_is_glyph
                                      |=> $stable(display_offset))
    else $error("glyph write shifted display");
  AST_WR_SHIFT: assert property (finish && st_reg.op == OP_DATA_WR && !ram_is_glyph && auto_shift
                                 |=> $changed(display_offset))
    else $error("entry shift missing after write");
  // The data lines are driven for one cycle after every read strobe and never otherwise,
  // so a host that samples late sees a released bus rather than old data.
  AST_OE_ON: assert property (enable_strobe && read_write |=> data_oe)
    else $error("read not answered");
  AST_OE_OFF: assert property (!(enable_strobe && read_write) |=> !data_oe)
    else $error("data lines driven without read");
  AST_NIB_LOW: assert property (!bus8 && enable_strobe && read_write
                                |=> data_out[3:0] == 4'h0)
    else $error("nibble read drove lower lines");
  AST_CFG_PHASE: assert property (finish && st_reg.op == OP_CONFIG |=> !st_reg.nib_lo)
    else $error("nibble phase not reset by configuration");
  AST_BUSY_KEEP: assert property (busy_flag && !finish |=> busy_flag)
    else $error("busy dropped before completion");
  // A stalled completion must keep the host out until the event has room.
  AST_STALL: assert property (st_reg.busy_flag && st_reg.exec_cnt == `CLIE_CNT_W'(1) && needs_event
                              && !fifo_ready |=> busy_flag)
    else $error("completion passed a full event queue");
  AST_EV_PUSH: assert property (push |=> ev_valid)
    else $error("event not queued");
  COV_WRITE: cover property (finish && st_reg.op == OP_DATA_WR);
  COV_SHIFT: cover property (finish && st_reg.op == OP_SHIFT && st_reg.arg[`CLIE_SC_BIT]);
  COV_NIBBLE: cover property (!bus8 && take && read_write);
  COV_STALL: cover property (st_reg.busy_flag && st_reg.exec_cnt == `CLIE_CNT_W'(1) && !fifo_ready);
  COV_READ: cover property (finish && st_reg.op == OP_DATA_RD);
endmodule : clie_engine
`default_nettype wire

//--- verilog/clie_defs.svh
// Constants of the character display instruction engine.
`ifndef CLIE_DEFS_SVH
`define CLIE_DEFS_SVH
`define CLIE_CLK_MHZ      10
`define CLIE_EXEC_NS      38000
`define CLIE_EXEC_CYCLES  ((`CLIE_EXEC_NS * `CLIE_CLK_MHZ) / 1000)
`define CLIE_CNT_W        9
`define CLIE_FIFO_DEPTH   16
`define CLIE_SC_BIT       3
`define CLIE_RL_BIT       2
`define CLIE_DL_BIT       4
`define CLIE_N_BIT        3
`define CLIE_F_BIT        2
`define CLIE_L1_BASE      7'h00
`define CLIE_L1_END       7'h27
`define CLIE_L2_BASE      7'h40
`define CLIE_L2_END       7'h67
`define CLIE_ONE_END      7'h4F
`define CLIE_CFG_RESET    3'h4
`endif

//--- verilog/clie_pkg.sv
// Types and shared decoding of the character display instruction engine.
`include "clie_defs.svh"
package clie_pkg;
  typedef struct packed {
    logic bus_width_sel;
    logic line_count_sel;
    logic font_sel;
  } clie_cfg_t;
  typedef enum logic [2:0] {
    OP_OTHER, OP_SHIFT, OP_CONFIG, OP_GLYPH_ADDR, OP_CHAR_ADDR, OP_DATA_WR, OP_DATA_RD
  } clie_op_t;
  typedef enum logic [1:0] {EV_CHAR_WR, EV_GLYPH_WR, EV_SHIFT_L, EV_SHIFT_R} clie_ev_kind_t;
  typedef struct packed {
    clie_ev_kind_t kind;
    logic [6:0]    addr;
    logic [7:0]    data;
  } clie_event_t;
  function automatic clie_op_t clie_decode(input logic [7:0] b);
    casez (b)
      8'b1???????: return OP_CHAR_ADDR;
      8'b01??????: return OP_GLYPH_ADDR;
      8'b001?????: return OP_CONFIG;
      8'b0001????: return OP_SHIFT;
      default:     return OP_OTHER;
    endcase
  endfunction : clie_decode
  // Steps the address counter with the wrap of the selected RAM and line mode.
  function automatic logic [6:0] clie_step(input logic [6:0] a, input logic up, input logic glyph,
                                           input logic two);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (glyph) r = {1'b0, r[5:0]};
    else if (two) begin
      if (up && a == `CLIE_L1_END) r = `CLIE_L2_BASE;
      else if (up && a == `CLIE_L2_END) r = `CLIE_L1_BASE;
      else if (!up && a == `CLIE_L1_BASE) r = `CLIE_L2_END;
      else if (!up && a == `CLIE_L2_BASE) r = `CLIE_L1_END;
    end else begin
      if (up && a == `CLIE_ONE_END) r = `CLIE_L1_BASE;
      else if (!up && a == `CLIE_L1_BASE) r = `CLIE_ONE_END;
    end
    return r;
  endfunction : clie_step
endpackage : clie_pkg

//--- tb/clie_host_model.sv
// Host processor model that drives the parallel instruction and data bus.
`timescale 1ns/1ps
`default_nettype none
module clie_host_model (
  input  wire logic       clk,      // System clock.
  input  wire logic [7:0] data_out, // Device data lines.
  input  wire logic       data_oe,  // Device drives the lines.
  output logic            strobe,   // Access strobe.
  output logic            rs,       // Register select.
  output logic            rw,       // 1 read, 0 write.
  output logic      [7:0] bus       // Host data lines.
);
  logic four_bit;
  initial begin
    four_bit = 1'b0;
    {strobe, rs, rw, bus} = 11'h0;
  end
  // Released lines show the inverse of the last value, so stale data never matches by luck.
  task automatic xfer(input logic r, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    {strobe, rs, rw, bus} = {1'b1, r, w, d};
    @(negedge clk);
    q = data_oe ? data_out : 8'hXX;
    strobe = 1'b0;
    bus = ~d;
  endtask : xfer
  task automatic access(input logic r, input logic w, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] h;
    logic [7:0] l;
    if (four_bit) begin
      xfer(r, w, {d[7:4], 4'h0}, h);
      xfer(r, w, {d[3:0], 4'h0}, l);
      q = {h[7:4], l[7:4]};
    end else begin
      xfer(r, w, d, q);
    end
  endtask : access
  // Status reads until the busy bit clears; bounded so a stuck device cannot hang the run.
  task automatic poll(output logic [7:0] st);
    for (int n = 0; n < 600; n++) begin
      access(1'b0, 1'b1, 8'h00, st);
      if (st[7] === 1'b0) break;
    end
  endtask : poll
endmodule : clie_host_model
`default_nettype wire

//--- tb/clie_engine_tb.sv
// Self-checking bench of the instruction engine with host model and random display side.
`timescale 1ns/1ps
`default_nettype none
module clie_engine_tb;
  import clie_pkg::*;
  localparam int BUSY_CYC = 380;
  logic        clk, reset, ev_ready, incr_decr, auto_shift, hold_ev;
  logic        strobe, rs, rw, oe, busy, glyph_o, ev_valid, glyph, two;
  logic [7:0]  din, dout, q;
  logic [6:0]  ac_o, off_o, ac, off;
  logic [2:0]  cfg_e;
  logic [33:0] e;
  logic [7:0]  cmem [0:127];
  logic [33:0] exq [$];
  clie_cfg_t   cfg_o;
  clie_event_t ev_word;
  int          mismatches, checked, cycles;

  clie_engine DUT (
    .clk(clk), .reset(reset), .enable_strobe(strobe), .register_select(rs), .read_write(rw), .data_in(din),
    .data_out(dout), .data_oe(oe), .incr_decr(incr_decr), .auto_shift(auto_shift), .busy_flag(busy),
    .addr_counter(ac_o), .ram_is_glyph(glyph_o), .cfg(cfg_o), .display_offset(off_o), .ev_valid(ev_valid),
    .ev_ready(ev_ready), .ev_word(ev_word));
  clie_host_model host (
    .clk(clk), .data_out(dout), .data_oe(oe), .strobe(strobe), .rs(rs), .rw(rw), .bus(din));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The display side takes events at random moments unless a scenario stalls it.
  always @(negedge clk) ev_ready <= hold_ev ? 1'b0 : 1'($urandom);
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      finish_test();
    end
    if (!reset && ev_valid === 1'b1 && ev_ready === 1'b1) begin
      e = exq.size() > 0 ? exq.pop_front() : 34'h3FFFFFFFF;
      chk(ev_word & e[33:17], e[16:0]);
    end
  end
////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] nxt(input logic [6:0] a, input logic up);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (glyph) return {1'b0, r[5:0]};
    if (two && up && a == 7'h27) return 7'h40;
    if (two && up && a == 7'h67) return 7'h00;
    if (two && !up && a == 7'h40) return 7'h27;
    if (two && !up && a == 7'h00) return 7'h67;
    if (!two && up && a == 7'h4F) return 7'h00;
    if (!two && !up && a == 7'h00) return 7'h4F;
    return r;
  endfunction : nxt
  function automatic logic [6:0] shf(input logic [6:0] o, input logic left);
    logic [6:0] m;
    m = two ? 7'h28 : 7'h50;
    if (left) return (o == m - 7'h01) ? 7'h00 : o + 7'h01;
    return (o == 7'h00) ? m - 7'h01 : o - 7'h01;
  endfunction : shf
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic verify();
    logic [7:0] st;
    host.poll(st);
    chk({st, off_o, glyph_o, 1'b0}, {1'b0, ac, off, glyph, 1'b0});
    chk({7'h0, ac_o, cfg_o}, {7'h0, ac, cfg_e});
  endtask : verify
  task automatic op(input logic r, input logic w, input logic [7:0] d);
    int   k;
    logic h;
    h = hold_ev;
    host.access(r, w, d, q);
    for (k = 0; k < 2000 && busy === 1'b1; k++) @(negedge clk);
    if (!h) chk(17'(k), 17'(BUSY_CYC));
    verify();
  endtask : op
  // Waits on the busy pin first so the host never polls across a width change.
  task automatic setup(input logic [2:0] c);
    host.access(1'b0, 1'b0, {3'h1, c, 2'h0}, q);
    cfg_e = c;
    two = c[1];
    for (int k = 0; k < 2000 && busy === 1'b1; k++) @(negedge clk);
    host.four_bit = !c[2];
    verify();
  endtask : setup
  task automatic load(input logic g, input logic [6:0] a);
    glyph = g;
    ac = g ? {1'b0, a[5:0]} : a;
    op(1'b0, 1'b0, g ? {2'h1, a[5:0]} : {1'b1, a});
  endtask : load
  task automatic wr(input logic [7:0] d);
    exq.push_back({17'h1FFFF, glyph ? EV_GLYPH_WR : EV_CHAR_WR, ac, d});
    if (!glyph) cmem[ac] = d;
    if (!glyph && auto_shift) off = shf(off, incr_decr);
    ac = nxt(ac, incr_decr);
    op(1'b1, 1'b0, d);
  endtask : wr
  task automatic rd(input logic [7:0] x, input logic v);
    ac = nxt(ac, incr_decr);
    op(1'b1, 1'b1, 8'h00);
    if (v) chk({9'h0, q}, {9'h0, x});
  endtask : rd
  task automatic shift(input logic sc, input logic rl);
    if (!sc) ac = nxt(ac, rl);
    else begin
      off = shf(off, !rl);
      exq.push_back({17'h18000, rl ? EV_SHIFT_R : EV_SHIFT_L, 15'h0});
    end
    op(1'b0, 1'b0, {4'h1, sc, rl, 2'h0});
  endtask : shift
  task automatic drain();
    for (int k = 0; k < 2000 && exq.size() != 0; k++) @(negedge clk);
  endtask : drain
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    hold_ev = 1'b0;
    incr_decr = 1'b1;
    auto_shift = 1'b0;
    ev_ready = 1'b0;
    {ac, off, glyph, two, cfg_e} = {16'h0, 3'h4};
    mismatches = 0;
    checked = 0;
    cycles = 0;
    void'($urandom(12479));
    repeat (10) @(negedge clk);
    reset = 1'b0;
    chk({5'h0, busy, ac_o, cfg_o, ev_valid}, {5'h0, 1'b0, 7'h00, 3'h4, 1'b0});
    for (int k = 3; k >= 0; k--) setup({1'b1, 2'(k)});
    $display("test reset_config done");
    load(1'b0, 7'h4F);
    wr(8'($urandom));
    incr_decr = 1'b0;
    wr(8'($urandom));
    setup(3'h6);
    load(1'b1, 7'($urandom));
    load(1'b0, 7'($urandom));
    ac = 7'h05;
    host.access(1'b0, 1'b0, 8'h85, q);
    host.access(1'b0, 1'b0, 8'hC0, q);
    verify();
    load(1'b0, 7'h40);
    for (int k = 0; k < 8; k++) shift(k[1], k[0]);
    shift(1'b0, 1'b1);
    $display("test address_shift done");
    auto_shift = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i == 8) load(1'b1, 7'h3E);
      incr_decr = 1'($urandom);
      wr(8'($urandom));
    end
    load(1'b0, 7'h10);
    incr_decr = 1'b1;
    for (int i = 0; i < 5; i++) wr(8'($urandom));
    load(1'b0, 7'h10);
    rd(cmem[7'h10], 1'b1);
    rd(cmem[7'h11], 1'b1);
    shift(1'b0, 1'b0);
    rd(cmem[7'h11], 1'b1);
    wr(8'h5A);
    rd(8'h00, 1'b0);
    rd(cmem[7'h14], 1'b1);
    setup(3'h2);
    load(1'b0, 7'h27);
    wr(8'($urandom));
    load(1'b0, 7'h45);
    wr(8'($urandom));
    load(1'b0, 7'h45);
    rd(cmem[7'h45], 1'b1);
    setup(3'h6);
    $display("test data_four_bit done");
    drain();
    hold_ev = 1'b1;
    for (int i = 0; i < 16; i++) wr(8'($urandom));
    fork
      wr(8'($urandom));
      begin
        repeat (800) @(negedge clk);
        chk({16'h0, busy}, 17'h1);
        hold_ev = 1'b0;
      end
    join
    drain();
    chk(17'(exq.size()), 17'h0);
    $display("test fifo done");
    finish_test();
  end
endmodule : clie_engine_tb
`default_nettype wire
